// ---- ssi_pkg.sv ----
// package: constants, states and parameter defaults of the sync status indicator
package ssi_pkg;

	// ---------------------------------------------------------------
	// synchronization states, best first (code order is the rank)
	// ---------------------------------------------------------------
	typedef enum logic [2:0]
	{
		SSI_SYNCED_REGULATED    = 3'h0,
		SSI_SYNCED_HOLDOFF      = 3'h1,
		SSI_SYNCED_SIMULATED    = 3'h2,
		SSI_CRYSTAL_PENDING_SYNC = 3'h3,
		SSI_CRYSTAL_FREEWHEEL   = 3'h4,
		SSI_CRYSTAL_SET_LOCAL   = 3'h5,
		SSI_TIME_INVALID        = 3'h6
	} ssi_state_t;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int unsigned SSI_CLK_HZ         = 10000000;
	localparam int unsigned SSI_FLASH_HALF_MS  = 500;     // half period of 1 Hz flash
	localparam int unsigned SSI_FLASH_HALF_CYC = SSI_CLK_HZ / 1000 * SSI_FLASH_HALF_MS;
	localparam int unsigned SSI_ACT_HOLD_MS    = 20;      // activity LED stretch
	localparam int unsigned SSI_ACT_HOLD_CYC   = SSI_CLK_HZ / 1000 * SSI_ACT_HOLD_MS;
	localparam int unsigned SSI_SEC_PER_DAY    = 86400;
	localparam int unsigned SSI_BACKUP_DAYS    = 3;
	localparam int unsigned SSI_BACKUP_SEC     = SSI_SEC_PER_DAY * SSI_BACKUP_DAYS;
	localparam int unsigned SSI_SEC_CYC        = SSI_CLK_HZ;  // cycles per second

	// ---------------------------------------------------------------
	// reset and default values of the time parameters
	// ---------------------------------------------------------------
	localparam logic [2:0]  SSI_THRESH_RST      = 3'h0;
	localparam logic        SSI_OFS_SIGN_DEF    = 1'h0;     // plus
	localparam logic [4:0]  SSI_OFS_HOUR_DEF    = 5'h00;
	localparam logic [5:0]  SSI_OFS_MIN_DEF     = 6'h00;
	localparam logic        SSI_DST_EN_DEF      = 1'h0;
	localparam logic [15:0] SSI_SYNC_ON_DEF     = 16'h0000; // minutes
	localparam logic [15:0] SSI_SYNC_OFF_DEF    = 16'h0002; // minutes
	localparam logic [31:0] SSI_LON_DEF         = 32'h0000_0000; // east 0
	localparam logic [31:0] SSI_LAT_DEF         = 32'h0000_0000; // north 0
	localparam logic        SSI_POSFIX_DEF      = 1'h1;
	localparam logic [31:0] SSI_BACKUP_SEC_RST  = 32'h0000_0000;

endpackage : ssi_pkg

// ---- ssi_pulse_div.sv ----
// file: divider making a one-cycle enable pulse every n cycles
`timescale 1ns/10ps
module ssi_pulse_div
	import ssi_pkg::*;
#(
	parameter int unsigned DIV = 16
)
(
	input  wire logic clock_i,
	input  wire logic nrst_i,
	output logic      tick_o
);

	localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [W-1:0] LAST = W'(DIV - 1);

	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	logic         tick_r;
	logic         tick_nxt;

	// count up to the last value, then wrap and pulse
	always_comb
	begin
		tick_nxt = (cnt_r == LAST);
		cnt_nxt  = tick_nxt ? '0 : cnt_r + W'(1);
	end

	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			cnt_r  <= '0;
			tick_r <= 1'b0;
		end
		else
		begin
			cnt_r  <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tick_o = tick_r;

endmodule : ssi_pulse_div

// ---- ssi_pin_sync.sv ----
// file: three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module ssi_pin_sync
(
	input  wire logic clock_i,
	input  wire logic nrst_i,
	input  wire logic pin_i,
	input  wire logic rst_val_i,
	output logic      level_o
);

	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic lvl_r;
	logic lvl_nxt;

	// accept a change only once the second and third stage agree
	always_comb
	begin
		lvl_nxt = (s2_r == s3_r) ? s2_r : lvl_r;
	end

	// idle level of a serial line is high, so stages reset high
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			s1_r  <= 1'b1;
			s2_r  <= 1'b1;
			s3_r  <= 1'b1;
			lvl_r <= 1'b1;
		end
		else
		begin
			s1_r  <= pin_i;
			s2_r  <= s1_r;
			s3_r  <= s2_r;
			lvl_r <= lvl_nxt;
		end
	end

	assign level_o = lvl_r;

endmodule : ssi_pin_sync

// ---- ssi_top.sv ----
// file: sync status indicator top: LEDs, status contact, activity LEDs, backup time, defaults
//
// How it works
// - regulated sync: red off, green steady
// - holdoff sync: red off, green flashing
// - simulated sync: red flashing, green steady
// - pending sync: both LEDs flashing
// - freewheel: both LEDs steady on
// - set local: red on, green flashing; invalid: red only
// - contact conducts when state at or above threshold
// - contact open when state below threshold
// - threshold register written over configuration link
// - rx and tx activity LEDs follow link data
// - backup seconds counter runs three days on stored energy
// - short outage resumes time from backup counter
// - reset command restarts controller to defined state
// - reset command keeps non-volatile parameters
// - load defaults erases leap-second information
// - load defaults zeroes offset, disables daylight changeover
// - load defaults: on delay zero, off delay two
// - load defaults: position zero, position-fix mode
`timescale 1ns/10ps
module ssi_top
	import ssi_pkg::*;
#(
	parameter int unsigned FLASH_HALF_CYC = SSI_FLASH_HALF_CYC,
	parameter int unsigned ACT_HOLD_CYC   = SSI_ACT_HOLD_CYC,
	parameter int unsigned SEC_CYC        = SSI_SEC_CYC,
	parameter int unsigned BACKUP_SEC     = SSI_BACKUP_SEC
)
(
	input  wire logic        clock_i,
	input  wire logic        nrst_i,
	// state from the time-keeping engine
	input  wire logic [2:0]  sync_state_i,
	// configuration writes, already decoded from the link
	input  wire logic        thresh_we_i,
	input  wire logic [2:0]  thresh_i,
	input  wire logic        reset_cmd_i,
	input  wire logic        defaults_cmd_i,
	// configuration serial link pins
	input  wire logic        link_rxd_i,
	input  wire logic        link_txd_i,
	// backup energy and main power
	input  wire logic        main_power_ok_i,
	input  wire logic        time_valid_i,
	// front panel
	output logic             led_red_o,
	output logic             led_green_o,
	output logic             status_contact_o,
	output logic             led_rx_o,
	output logic             led_tx_o,
	// controller restart and parameters
	output logic             ctrl_restart_o,
	output logic [2:0]       thresh_o,
	output logic             leap_valid_o,
	output logic             ofs_sign_o,
	output logic [4:0]       ofs_hour_o,
	output logic [5:0]       ofs_min_o,
	output logic             dst_start_en_o,
	output logic             dst_end_en_o,
	output logic [15:0]      sync_on_delay_o,
	output logic [15:0]      sync_off_delay_o,
	output logic [31:0]      pos_lon_o,
	output logic [31:0]      pos_lat_o,
	output logic             posfix_mode_o,
	output logic [31:0]      backup_sec_o,
	output logic             resume_from_backup_o
);

	// ---------------------------------------------------------------
	// rank helper
	// ---------------------------------------------------------------
	// lower code is better; unknown codes count as worst
	function automatic logic [2:0] ssi_rank(input logic [2:0] s);
		ssi_rank = (s > SSI_TIME_INVALID) ? SSI_TIME_INVALID : s;
	endfunction : ssi_rank

	// ---------------------------------------------------------------
	// enables and synchronisers
	// ---------------------------------------------------------------
	logic flash_tick;
	logic sec_tick;
	logic rxd_lvl;
	logic txd_lvl;

	ssi_pulse_div #(.DIV(FLASH_HALF_CYC)) u_flash_div
	(
		.clock_i (clock_i),
		.nrst_i  (nrst_i),
		.tick_o  (flash_tick)
	);

	ssi_pulse_div #(.DIV(SEC_CYC)) u_sec_div
	(
		.clock_i (clock_i),
		.nrst_i  (nrst_i),
		.tick_o  (sec_tick)
	);

	ssi_pin_sync u_rxd_sync
	(
		.clock_i   (clock_i),
		.nrst_i    (nrst_i),
		.pin_i     (link_rxd_i),
		.rst_val_i (1'b1),
		.level_o   (rxd_lvl)
	);

	// txd comes from our own uart on this clock, no synchroniser needed
	assign txd_lvl = link_txd_i;

	// ---------------------------------------------------------------
	// LED and contact encoding
	// ---------------------------------------------------------------
	logic       phase_r;
	logic       phase_nxt;
	logic       red_r;
	logic       red_nxt;
	logic       green_r;
	logic       green_nxt;
	logic       contact_r;
	logic       contact_nxt;
	logic [2:0] thresh_r;
	logic [2:0] thresh_nxt;

	// one shared phase keeps both LEDs flashing together
	always_comb
	begin
		phase_nxt = flash_tick ? ~phase_r : phase_r;
		red_nxt   = 1'b1;
		green_nxt = 1'b0;
		case (sync_state_i)
			SSI_SYNCED_REGULATED:
			begin
				red_nxt   = 1'b0;
				green_nxt = 1'b1;
			end
			SSI_SYNCED_HOLDOFF:
			begin
				red_nxt   = 1'b0;
				green_nxt = phase_r;
			end
			SSI_SYNCED_SIMULATED:
			begin
				red_nxt   = phase_r;
				green_nxt = 1'b1;
			end
			SSI_CRYSTAL_PENDING_SYNC:
			begin
				red_nxt   = phase_r;
				green_nxt = phase_r;
			end
			SSI_CRYSTAL_FREEWHEEL:
			begin
				red_nxt   = 1'b1;
				green_nxt = 1'b1;
			end
			SSI_CRYSTAL_SET_LOCAL:
			begin
				red_nxt   = 1'b1;
				green_nxt = phase_r;
			end
			default:
			begin
				red_nxt   = 1'b1;
				green_nxt = 1'b0;
			end
		endcase
		// threshold survives a restart command; it lives in storage
		thresh_nxt  = thresh_we_i ? ssi_rank(thresh_i) : thresh_r;
		// conduct at or better than threshold, block otherwise
		contact_nxt = (ssi_rank(sync_state_i) <= thresh_r);
	end

	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			phase_r   <= 1'b0;
			red_r     <= 1'b1;
			green_r   <= 1'b0;
			contact_r <= 1'b0;
			thresh_r  <= SSI_THRESH_RST;
		end
		else
		begin
			phase_r   <= phase_nxt;
			red_r     <= red_nxt;
			green_r   <= green_nxt;
			contact_r <= contact_nxt;
			thresh_r  <= thresh_nxt;
		end
	end

	// ---------------------------------------------------------------
	// link activity LEDs
	// ---------------------------------------------------------------
	// a start bit is low; stretching makes single bytes visible
	localparam int unsigned AW = $clog2(ACT_HOLD_CYC + 1);
	localparam logic [AW-1:0] ACT_LOAD = AW'(ACT_HOLD_CYC);

	logic [AW-1:0] rx_cnt_r;
	logic [AW-1:0] rx_cnt_nxt;
	logic [AW-1:0] tx_cnt_r;
	logic [AW-1:0] tx_cnt_nxt;
	logic          led_rx_r;
	logic          led_rx_nxt;
	logic          led_tx_r;
	logic          led_tx_nxt;

	always_comb
	begin
		rx_cnt_nxt = !rxd_lvl ? ACT_LOAD : (rx_cnt_r != '0 ? rx_cnt_r - AW'(1) : rx_cnt_r);
		tx_cnt_nxt = !txd_lvl ? ACT_LOAD : (tx_cnt_r != '0 ? tx_cnt_r - AW'(1) : tx_cnt_r);
		led_rx_nxt = (rx_cnt_nxt != '0);
		led_tx_nxt = (tx_cnt_nxt != '0);
	end

	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rx_cnt_r <= '0;
			tx_cnt_r <= '0;
			led_rx_r <= 1'b0;
			led_tx_r <= 1'b0;
		end
		else
		begin
			rx_cnt_r <= rx_cnt_nxt;
			tx_cnt_r <= tx_cnt_nxt;
			led_rx_r <= led_rx_nxt;
			led_tx_r <= led_tx_nxt;
		end
	end

	// ---------------------------------------------------------------
	// backup time counter
	// ---------------------------------------------------------------
	// counts seconds always; outage length is measured while power is off
	logic [31:0] bsec_r;
	logic [31:0] bsec_nxt;
	logic [31:0] outage_r;
	logic [31:0] outage_nxt;
	logic        pwr_r;
	logic        pwr_nxt;
	logic        resume_r;
	logic        resume_nxt;

	always_comb
	begin
		pwr_nxt    = main_power_ok_i;
		bsec_nxt   = sec_tick ? bsec_r + 32'h1 : bsec_r;
		outage_nxt = outage_r;
		if (!main_power_ok_i && sec_tick && outage_r != 32'hffff_ffff)
			outage_nxt = outage_r + 32'h1;
		resume_nxt = 1'b0;
		// resume only if the outage fit the span and no valid time exists
		if (main_power_ok_i && !pwr_r)
		begin
			resume_nxt = (outage_r < 32'(BACKUP_SEC)) && !time_valid_i;
			outage_nxt = 32'h0;
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			bsec_r   <= SSI_BACKUP_SEC_RST;
			outage_r <= 32'h0;
			pwr_r    <= 1'b0;
			resume_r <= 1'b0;
		end
		else
		begin
			bsec_r   <= bsec_nxt;
			outage_r <= outage_nxt;
			pwr_r    <= pwr_nxt;
			resume_r <= resume_nxt;
		end
	end

	// ---------------------------------------------------------------
	// commands and stored parameters
	// ---------------------------------------------------------------
	// parameters here stand for non-volatile copies: only defaults touch them
	logic        restart_r;
	logic        restart_nxt;
	logic        leap_r;
	logic        leap_nxt;
	logic        sign_r;
	logic        sign_nxt;
	logic [4:0]  hour_r;
	logic [4:0]  hour_nxt;
	logic [5:0]  min_r;
	logic [5:0]  min_nxt;
	logic        dst_s_r;
	logic        dst_s_nxt;
	logic        dst_e_r;
	logic        dst_e_nxt;
	logic [15:0] son_r;
	logic [15:0] son_nxt;
	logic [15:0] soff_r;
	logic [15:0] soff_nxt;
	logic [31:0] lon_r;
	logic [31:0] lon_nxt;
	logic [31:0] lat_r;
	logic [31:0] lat_nxt;
	logic        pfix_r;
	logic        pfix_nxt;

	always_comb
	begin
		restart_nxt = reset_cmd_i;
		leap_nxt    = leap_r;
		sign_nxt    = sign_r;
		hour_nxt    = hour_r;
		min_nxt     = min_r;
		dst_s_nxt   = dst_s_r;
		dst_e_nxt   = dst_e_r;
		son_nxt     = son_r;
		soff_nxt    = soff_r;
		lon_nxt     = lon_r;
		lat_nxt     = lat_r;
		pfix_nxt    = pfix_r;
		if (defaults_cmd_i)
		begin
			leap_nxt  = 1'b0;
			sign_nxt  = SSI_OFS_SIGN_DEF;
			hour_nxt  = SSI_OFS_HOUR_DEF;
			min_nxt   = SSI_OFS_MIN_DEF;
			dst_s_nxt = SSI_DST_EN_DEF;
			dst_e_nxt = SSI_DST_EN_DEF;
			son_nxt   = SSI_SYNC_ON_DEF;
			soff_nxt  = SSI_SYNC_OFF_DEF;
			lon_nxt   = SSI_LON_DEF;
			lat_nxt   = SSI_LAT_DEF;
			pfix_nxt  = SSI_POSFIX_DEF;
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			restart_r <= 1'b0;
			leap_r    <= 1'b0;
			sign_r    <= SSI_OFS_SIGN_DEF;
			hour_r    <= SSI_OFS_HOUR_DEF;
			min_r     <= SSI_OFS_MIN_DEF;
			dst_s_r   <= SSI_DST_EN_DEF;
			dst_e_r   <= SSI_DST_EN_DEF;
			son_r     <= SSI_SYNC_ON_DEF;
			soff_r    <= SSI_SYNC_OFF_DEF;
			lon_r     <= SSI_LON_DEF;
			lat_r     <= SSI_LAT_DEF;
			pfix_r    <= SSI_POSFIX_DEF;
		end
		else
		begin
			restart_r <= restart_nxt;
			leap_r    <= leap_nxt;
			sign_r    <= sign_nxt;
			hour_r    <= hour_nxt;
			min_r     <= min_nxt;
			dst_s_r   <= dst_s_nxt;
			dst_e_r   <= dst_e_nxt;
			son_r     <= son_nxt;
			soff_r    <= soff_nxt;
			lon_r     <= lon_nxt;
			lat_r     <= lat_nxt;
			pfix_r    <= pfix_nxt;
		end
	end

	// ---------------------------------------------------------------
	// outputs, all from flip-flops
	// ---------------------------------------------------------------
	assign led_red_o            = red_r;
	assign led_green_o          = green_r;
	assign status_contact_o     = contact_r;
	assign led_rx_o             = led_rx_r;
	assign led_tx_o             = led_tx_r;
	assign ctrl_restart_o       = restart_r;
	assign thresh_o             = thresh_r;
	assign leap_valid_o         = leap_r;
	assign ofs_sign_o           = sign_r;
	assign ofs_hour_o           = hour_r;
	assign ofs_min_o            = min_r;
	assign dst_start_en_o       = dst_s_r;
	assign dst_end_en_o         = dst_e_r;
	assign sync_on_delay_o      = son_r;
	assign sync_off_delay_o     = soff_r;
	assign pos_lon_o            = lon_r;
	assign pos_lat_o            = lat_r;
	assign posfix_mode_o        = pfix_r;
	assign backup_sec_o         = bsec_r;
	assign resume_from_backup_o = resume_r;

endmodule : ssi_top

// ---- ssi_top_assertions.sv ----
// checker: port-level properties of the sync status indicator
`timescale 1ns/10ps
module ssi_top_assertions
#(
	parameter int unsigned ACT_HOLD_CYC = 3
)
(
	input wire logic        clock_i,
	input wire logic        nrst_i,
	input wire logic [2:0]  sync_state_i,
	input wire logic        thresh_we_i,
	input wire logic [2:0]  thresh_i,
	input wire logic        reset_cmd_i,
	input wire logic        defaults_cmd_i,
	input wire logic        link_txd_i,
	input wire logic        led_red_o,
	input wire logic        led_green_o,
	input wire logic        status_contact_o,
	input wire logic        led_tx_o,
	input wire logic        ctrl_restart_o,
	input wire logic [2:0]  thresh_o,
	input wire logic        leap_valid_o,
	input wire logic        ofs_sign_o,
	input wire logic [4:0]  ofs_hour_o,
	input wire logic [5:0]  ofs_min_o,
	input wire logic        dst_start_en_o,
	input wire logic        dst_end_en_o,
	input wire logic [15:0] sync_on_delay_o,
	input wire logic [15:0] sync_off_delay_o,
	input wire logic [31:0] pos_lon_o,
	input wire logic [31:0] pos_lat_o,
	input wire logic        posfix_mode_o
);
	logic       live_r; // first edge after release still shows reset values
	logic [7:0] txhi_r; // cycles the tx line has been idle

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!nrst_i);

	// helper counters
	always_ff @(posedge clock_i or negedge nrst_i)
		if (!nrst_i) live_r <= 1'b0;
		else live_r <= 1'b1;
	always_ff @(posedge clock_i or negedge nrst_i)
		if (!nrst_i) txhi_r <= 8'h00;
		else if (!link_txd_i) txhi_r <= 8'h00;
		else if (txhi_r != 8'hff) txhi_r <= txhi_r + 8'h01;

	sequence was_s(logic [2:0] s);
		live_r && $past(sync_state_i) == s;
	endsequence
	sequence defaults_s;
		!leap_valid_o && !ofs_sign_o && ofs_hour_o == 5'h00 && ofs_min_o == 6'h00 && !dst_start_en_o
		&& !dst_end_en_o && sync_on_delay_o == 16'h0000 && sync_off_delay_o == 16'h0002
		&& pos_lon_o == 32'h0 && pos_lat_o == 32'h0 && posfix_mode_o;
	endsequence

	regulated_leds_a: assert property (was_s(3'h0) |-> !led_red_o && led_green_o)
		else $error("regulated state LEDs wrong");
	holdoff_red_a: assert property (was_s(3'h1) |-> !led_red_o)
		else $error("holdoff state red LED lit");
	simulated_green_a: assert property (was_s(3'h2) |-> led_green_o)
		else $error("simulated state green LED dark");
	pending_phase_a: assert property (was_s(3'h3) |-> led_red_o == led_green_o)
		else $error("pending state LEDs out of phase");
	freewheel_leds_a: assert property (was_s(3'h4) |-> led_red_o && led_green_o)
		else $error("freewheel state LEDs wrong");
	invalid_leds_a: assert property (live_r && $past(sync_state_i) >= 3'h5 |-> led_red_o && !($past(sync_state_i) != 3'h5 && led_green_o))
		else $error("set local or invalid LEDs wrong");
	contact_rank_a: assert property (live_r |-> status_contact_o ==
		((($past(sync_state_i) == 3'h7) ? 3'h6 : $past(sync_state_i)) <= $past(thresh_o)))
		else $error("status contact disagrees with threshold");
	thresh_write_a: assert property (thresh_we_i && thresh_i != 3'h7 |=> thresh_o == $past(thresh_i))
		else $error("threshold write not taken");
	restart_copy_a: assert property (live_r |-> ctrl_restart_o == $past(reset_cmd_i))
		else $error("restart pulse does not follow command");
	restart_keeps_a: assert property (reset_cmd_i && !thresh_we_i && !defaults_cmd_i |=> $stable(thresh_o))
		else $error("restart changed the threshold");
	defaults_load_a: assert property (defaults_cmd_i |=> defaults_s)
		else $error("default values not loaded");
	tx_on_a: assert property (!link_txd_i |=> led_tx_o)
		else $error("tx LED dark while sending");
	tx_off_a: assert property (txhi_r >= ACT_HOLD_CYC + 2 |-> !led_tx_o)
		else $error("tx LED lit on idle line");
endmodule : ssi_top_assertions

bind ssi_top ssi_top_assertions #(.ACT_HOLD_CYC(ACT_HOLD_CYC)) u_chk (.*);

// ---- ssi_cfg_pc_model.sv ----
// model: configuration PC writing the threshold and sending serial frames
`timescale 1ns/10ps
module ssi_cfg_pc_model
#(
	parameter int unsigned BIT_CYC = 8
)
(
	input  wire logic       clock_i,
	input  wire logic       cfg_go_i,
	input  wire logic [2:0] cfg_val_i,
	input  wire logic       frame_go_i,
	input  wire logic [7:0] frame_byte_i,
	output logic            thresh_we_o,
	output logic [2:0]      thresh_o,
	output logic            reset_cmd_o,
	output logic            rxd_o,
	output logic            busy_o
);
	logic [9:0] sh_r;   // frame bits, lsb leaves first
	logic [3:0] bits_r;
	int         cnt_r;

	initial
	begin
		thresh_we_o = 1'b0;
		thresh_o    = 3'h0;
		reset_cmd_o = 1'b0;
		sh_r        = 10'h3ff;
		bits_r      = 4'h0;
		cnt_r       = 0;
	end

	// lines change after the falling edge; an unused threshold bus toggles so stray sampling shows
	always @(negedge clock_i)
	begin
		thresh_we_o <= cfg_go_i;
		thresh_o    <= cfg_go_i ? ((cfg_val_i == 3'h7) ? 3'h6 : cfg_val_i) : ~thresh_o;
		reset_cmd_o <= thresh_we_o; // a write is always followed by a restart
		if (frame_go_i && bits_r == 4'h0)
		begin
			sh_r   <= {1'b1, frame_byte_i, 1'b0};
			bits_r <= 4'ha;
			cnt_r  <= 0;
		end
		else if (bits_r != 4'h0 && cnt_r == BIT_CYC - 1)
		begin
			sh_r   <= {1'b1, sh_r[9:1]};
			bits_r <= bits_r - 4'h1;
			cnt_r  <= 0;
		end
		else if (bits_r != 4'h0)
			cnt_r <= cnt_r + 1;
	end

	assign rxd_o  = (bits_r != 4'h0) ? sh_r[0] : 1'b1; // mark level between frames
	assign busy_o = thresh_we_o | reset_cmd_o | (bits_r != 4'h0);
endmodule : ssi_cfg_pc_model

// ---- sync_status_indicator_tb_top.sv ----
// testbench: sync status indicator with a configuration PC model
`timescale 1ns/10ps
module sync_status_indicator_tb_top;
	import ssi_pkg::*;
	typedef struct {int sel; logic [31:0] v;} ssi_note_t;
	localparam int ACT = 3;
	logic        clock_i, nrst_i, we, rcmd, dflt, rxd, txd, pwr, tval, go, fgo, busy;
	logic [2:0]  state, thr, val, thro;
	logic [7:0]  fbyte;
	logic        red, grn, cont, lrx, ltx, rstrt, leap, osign, dsts, dste, pfix, resume;
	logic [4:0]  ohr;
	logic [5:0]  omin;
	logic [15:0] ondly, offdly;
	logic [31:0] lon, lat, bsec, b0, cnt, prev, got, seed;
	int          errors, n_checks;
	int          rc[8] = '{0, 0, 2, 2, 1, 1, 1, 1};
	int          gc[8] = '{1, 2, 1, 2, 1, 2, 0, 0};
	int          fl[4] = '{1, 2, 3, 5};
	ssi_note_t   q[$];
	ssi_note_t   nt;
	event        look;

	ssi_top #(.FLASH_HALF_CYC(4), .ACT_HOLD_CYC(ACT), .SEC_CYC(5), .BACKUP_SEC(4)) DUT (
		.clock_i(clock_i), .nrst_i(nrst_i), .sync_state_i(state), .thresh_we_i(we), .thresh_i(thr),
		.reset_cmd_i(rcmd), .defaults_cmd_i(dflt), .link_rxd_i(rxd), .link_txd_i(txd),
		.main_power_ok_i(pwr), .time_valid_i(tval), .led_red_o(red), .led_green_o(grn),
		.status_contact_o(cont), .led_rx_o(lrx), .led_tx_o(ltx), .ctrl_restart_o(rstrt), .thresh_o(thro),
		.leap_valid_o(leap), .ofs_sign_o(osign), .ofs_hour_o(ohr), .ofs_min_o(omin), .dst_start_en_o(dsts),
		.dst_end_en_o(dste), .sync_on_delay_o(ondly), .sync_off_delay_o(offdly), .pos_lon_o(lon),
		.pos_lat_o(lat), .posfix_mode_o(pfix), .backup_sec_o(bsec), .resume_from_backup_o(resume));
	ssi_cfg_pc_model #(.BIT_CYC(8)) PC (.clock_i(clock_i), .cfg_go_i(go), .cfg_val_i(val),
		.frame_go_i(fgo), .frame_byte_i(fbyte), .thresh_we_o(we), .thresh_o(thr), .reset_cmd_o(rcmd),
		.rxd_o(rxd), .busy_o(busy));

	// clock, and a watchdog well beyond the expected run
	initial
	begin
		clock_i = 1'b0;
		forever #50 clock_i = ~clock_i;
	end
	initial
	begin
		#3000000;
		errors++;
		wrap_up();
	end

	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs
	function automatic logic [31:0] obs(input int s);
		case (s)
			0: return {31'h0, red};
			1: return {31'h0, grn};
			2: return {31'h0, cont};
			3: return {29'h0, thro};
			4: return {16'h0, leap, osign, ohr, omin, dsts, dste, pfix};
			5: return {ondly, offdly};
			6: return lon | lat;
			7: return {31'h0, ltx};
			8: return {31'h0, lrx};
			default: return cnt;
		endcase
	endfunction : obs
	task automatic cyc(input int n);
		repeat (n) @(negedge clock_i);
	endtask : cyc
	task automatic expect_now(input int s, input logic [31:0] v);
		q.push_back('{s, v});
		-> look;
	endtask : expect_now
	task automatic wrap_up();
		#1;
		if (errors == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up
	// threshold write through the PC model; it restarts the board afterwards
	task automatic pc_cfg(input logic [2:0] v);
		int n;
		go <= 1'b1;
		val <= v;
		cyc(1);
		go <= 1'b0;
		n = 0;
		do
		begin
			cyc(1);
			n++;
		end
		while (busy && n < 20);
		cyc(1);
	endtask : pc_cfg
	task automatic check_state(input logic [2:0] s, input int t);
		state = s;
		cyc(2);
		expect_now(2, 32'(((s == 3'h7) ? 3'h6 : s) <= t));
		if (rc[s] != 2) expect_now(0, 32'(rc[s]));
		if (gc[s] != 2) expect_now(1, 32'(gc[s]));
	endtask : check_state

	// monitor: checks every queued note, oldest first, whenever results are posted
	initial
	forever
	begin
		@(look);
		while (q.size() != 0)
		begin
			nt = q.pop_front();
			got = obs(nt.sel);
			n_checks++;
			if (got !== nt.v)
			begin
				errors++;
				$display("[ERR] %0t sel %0d exp %h got %h", $time, nt.sel, nt.v, got);
			end
		end
	end

	// main sequence
	initial
	begin
		{state, dflt, go, val, fgo, fbyte, tval, errors, n_checks} = '0;
		{txd, pwr} = 2'h3;
		seed = 32'h5610fa78;
		nrst_i = 1'b0;
		cyc(16);
		nrst_i = 1'b1;
		for (int t = 0; t < 7; t++)
		begin
			pc_cfg(3'(t));
			expect_now(3, 32'(t));
			for (int s = 0; s < 8; s++) check_state(3'(s), t);
		end
		repeat (12)
		begin
			seed = xs(seed);
			pc_cfg(seed[2:0]);
			expect_now(3, (seed[2:0] == 3'h7) ? 32'h6 : 32'(seed[2:0]));
			check_state(seed[10:8], (seed[2:0] == 3'h7) ? 6 : int'(seed[2:0]));
		end
		// flashing LEDs toggle every half period, so 40 samples hold exactly 10 changes
		foreach (fl[i])
		begin
			state = 3'(fl[i]);
			cyc(2);
			cnt = 0;
			prev = obs((rc[fl[i]] == 2) ? 0 : 1);
			repeat (40)
			begin
				cyc(1);
				got = obs((rc[fl[i]] == 2) ? 0 : 1);
				if (got != prev) cnt++;
				prev = got;
			end
			expect_now(9, 32'h0a);
		end
		dflt = 1'b1;
		cyc(1);
		dflt = 1'b0;
		expect_now(4, 32'h0001);
		expect_now(5, 32'h0000_0002);
		expect_now(6, 32'h0);
		txd = 1'b0;
		cyc(1);
		txd = 1'b1;
		expect_now(7, 32'h1);
		cyc(ACT + 3);
		expect_now(7, 32'h0);
		fbyte <= 8'h00;
		fgo <= 1'b1;
		cyc(1);
		fgo <= 1'b0;
		cyc(12);
		expect_now(8, 32'h1);
		for (int n = 0; n < 200 && busy; n++) cyc(1);
		cyc(ACT + 8);
		expect_now(8, 32'h0);
		// short outage resumes from backup, a long one does not
		for (int k = 0; k < 2; k++)
		begin
			pwr = 1'b0;
			cyc(k ? 40 : 10);
			pwr = 1'b1;
			cnt = 0;
			repeat (8)
			begin
				cyc(1);
				if (resume === 1'b1) cnt++;
			end
			expect_now(9, k ? 32'h0 : 32'h1);
		end
		b0 = bsec;
		cyc(50);
		cnt = bsec - b0;
		expect_now(9, 32'h0a);
		wrap_up();
	end
endmodule : sync_status_indicator_tb_top
